// ===== pfta_flash_dev.sv
// Table access, holding registers and self-timed erase/program control
module pfta_flash_dev #(
  parameter int ERASE_TIME_US = 1000,
  parameter int PROG_TIME_US = 1000
) (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  pfta_if.dev LINK,
  output logic [pfta_pkg::ADDR_W-1:0] FLASH_RD_ADDR_O,
  input wire logic [pfta_pkg::WORD_W-1:0] FLASH_RD_DATA_I,
  output logic FLASH_ERASE_O,
  output logic FLASH_PROG_O,
  output logic FLASH_PROG_WORD_O,
  output logic [pfta_pkg::BLK_W-1:0] FLASH_BLOCK_O,
  output logic [pfta_pkg::HOLD_IDX_W-1:0] FLASH_WORD_OFS_O,
  output logic [pfta_pkg::HOLD_N*8-1:0] FLASH_PROG_DATA_O,
  output logic FLASH_BUSY_O
);
  import pfta_pkg::*;

  localparam logic [CNT_W-1:0] ERASE_CYC = CNT_W'(ERASE_TIME_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] PROG_CYC = CNT_W'(PROG_TIME_US * CLK_MHZ);

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} pfta_key_t;

  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] eff_ptr;
  logic [ADDR_W-1:0] next_ptr;
  logic [7:0] table_latch;
  logic word_sel, erase_sel, err_flag, allow, kick;
  logic [7:0] hold [HOLD_N];
  logic rd_pend;
  logic take, launch;
  logic timer_done;
  logic [7:0] ctrl_image;
  logic [7:0] rd_byte;
  pfta_key_t key_stage;

  ////////////////////////////////////////////////////////////////////////
  // Request acceptance
  // Nothing is taken while the array is tied up or a read is in flight
  assign LINK.req_ready = !kick && !rd_pend;
  assign LINK.stall = kick;
  assign take = LINK.req_valid && LINK.req_ready;

  assign launch = take && LINK.req_op == OP_REG_WR &&
    LINK.req_reg == REG_CTRL && LINK.req_wdata[CTRL_KICK] &&
    LINK.req_wdata[CTRL_ALLOW] && key_stage == KEY_ARMED;

  always_comb
  begin
    eff_ptr = (LINK.req_mode == PTR_PRE_INC) ? pfta_step(ptr, 1'b1) : ptr;
    case (LINK.req_mode)
      PTR_KEEP: next_ptr = ptr;
      PTR_POST_INC: next_ptr = pfta_step(ptr, 1'b1);
      PTR_POST_DEC: next_ptr = pfta_step(ptr, 1'b0);
      PTR_PRE_INC: next_ptr = eff_ptr;
      default: next_ptr = ptr;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Unlock sequence: any other request in between breaks it
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      key_stage <= KEY_IDLE;
    else if (take)
    begin
      if (LINK.req_op == OP_REG_WR && LINK.req_reg == REG_KEY &&
          LINK.req_wdata == KEY_FIRST)
        key_stage <= KEY_HALF;
      else if (key_stage == KEY_HALF && LINK.req_op == OP_REG_WR &&
          LINK.req_reg == REG_KEY && LINK.req_wdata == KEY_SECOND)
        key_stage <= KEY_ARMED;
      else
        key_stage <= KEY_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table pointer
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      ptr <= '0;
    else if (take)
    begin
      case (LINK.req_op)
        OP_REG_WR:
        begin
          case (LINK.req_reg)
            REG_PTR_LOW: ptr[7:0] <= LINK.req_wdata;
            REG_PTR_HIGH: ptr[15:8] <= LINK.req_wdata;
            REG_PTR_UPPER: ptr[ADDR_W-1:16] <= LINK.req_wdata[UPPER_W-1:0];
            default: ptr <= ptr;
          endcase
        end
        OP_TBL_RD, OP_TBL_WR: ptr <= next_ptr;
        default: ptr <= ptr;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table reads: all 22 bits go out, top bit picks config space
  assign rd_byte = FLASH_RD_ADDR_O[0] ? FLASH_RD_DATA_I[15:8] :
    FLASH_RD_DATA_I[7:0];

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      FLASH_RD_ADDR_O <= '0;
      rd_pend <= 1'b0;
    end
    else
    begin
      rd_pend <= take && LINK.req_op == OP_TBL_RD;
      if (take && LINK.req_op == OP_TBL_RD)
        FLASH_RD_ADDR_O <= eff_ptr;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      table_latch <= ZERO_BYTE;
    else if (rd_pend)
      table_latch <= rd_byte;
    else if (take && LINK.req_op == OP_REG_WR && LINK.req_reg == REG_LATCH)
      table_latch <= LINK.req_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Holding registers: short writes only, never cleared by programming
  genvar gi;
  generate
    for (gi = 0; gi < HOLD_N; gi++)
    begin : g_hold
      always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
      begin
        if (!ARST_N_I)
          hold[gi] <= ZERO_BYTE;
        else if (take && LINK.req_op == OP_TBL_WR &&
            eff_ptr[HOLD_IDX_W-1:0] == HOLD_IDX_W'(gi))
          hold[gi] <= table_latch;
      end
      assign FLASH_PROG_DATA_O[gi*8 +: 8] = hold[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Control bits
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      word_sel <= 1'b0;
      erase_sel <= 1'b0;
      allow <= 1'b0;
      err_flag <= 1'b0;
      kick <= 1'b0;
    end
    else
    begin
      if (take && LINK.req_op == OP_REG_WR && LINK.req_reg == REG_CTRL)
      begin
        word_sel <= LINK.req_wdata[CTRL_WORD];
        erase_sel <= LINK.req_wdata[CTRL_ERASE];
        allow <= LINK.req_wdata[CTRL_ALLOW];
        err_flag <= LINK.req_wdata[CTRL_ERR];
      end
      if (launch)
      begin
        kick <= 1'b1;
        err_flag <= 1'b1;
      end
      if (timer_done)
      begin
        kick <= 1'b0;
        err_flag <= 1'b0;
        if (erase_sel)
          erase_sel <= 1'b0;
      end
    end
  end

  assign ctrl_image = {2'b00, word_sel, erase_sel, err_flag, allow, kick,
    1'b0};

  ////////////////////////////////////////////////////////////////////////
  // Launch of the long write toward the array
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      FLASH_ERASE_O <= 1'b0;
      FLASH_PROG_O <= 1'b0;
      FLASH_PROG_WORD_O <= 1'b0;
      FLASH_BLOCK_O <= '0;
      FLASH_WORD_OFS_O <= '0;
    end
    else
    begin
      // Erase needs both allow and erase select in the launching write
      FLASH_ERASE_O <= launch && LINK.req_wdata[CTRL_ERASE];
      FLASH_PROG_O <= launch && !LINK.req_wdata[CTRL_ERASE];
      if (launch)
      begin
        // Only whole 1024-byte blocks are erased, low bits dropped
        FLASH_BLOCK_O <= ptr[ADDR_W-1:BLK_LSB];
        FLASH_PROG_WORD_O <= LINK.req_wdata[CTRL_WORD];
        FLASH_WORD_OFS_O <= {ptr[HOLD_IDX_W-1:1], 1'b0};
      end
    end
  end

  pfta_op_timer i_pfta_op_timer (
    .clk_i(SYS_CLK_I),
    .arst_n_i(ARST_N_I),
    .start_i(launch),
    .count_i(LINK.req_wdata[CTRL_ERASE] ? ERASE_CYC : PROG_CYC),
    .active_o(FLASH_BUSY_O),
    .done_o(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Responses; the key register always reads zero
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_rdata <= ZERO_BYTE;
    end
    else
    begin
      LINK.rsp_valid <= rd_pend || (take && LINK.req_op == OP_REG_RD);
      if (rd_pend)
        LINK.rsp_rdata <= rd_byte;
      else if (take && LINK.req_op == OP_REG_RD)
      begin
        case (LINK.req_reg)
          REG_PTR_LOW: LINK.rsp_rdata <= ptr[7:0];
          REG_PTR_HIGH: LINK.rsp_rdata <= ptr[15:8];
          REG_PTR_UPPER: LINK.rsp_rdata <= {2'b00, ptr[ADDR_W-1:16]};
          REG_LATCH: LINK.rsp_rdata <= table_latch;
          REG_CTRL: LINK.rsp_rdata <= ctrl_image;
          default: LINK.rsp_rdata <= ZERO_BYTE;
        endcase
      end
    end
  end
endmodule

// ===== pfta_pkg.sv
// Shared constants, types and helpers for the table access block
package pfta_pkg;
  localparam int ADDR_W = 22;
  localparam int LOW_W = 21;
  localparam int WORD_W = 16;
  localparam int BLK_LSB = 10;
  localparam int BLK_W = 12;
  localparam int HOLD_N = 64;
  localparam int HOLD_IDX_W = 6;
  localparam int UPPER_W = 6;
  localparam int CNT_W = 24;
  localparam int CLK_MHZ = 200;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int CTRL_WORD = 5;
  localparam int CTRL_ERASE = 4;
  localparam int CTRL_ERR = 3;
  localparam int CTRL_ALLOW = 2;
  localparam int CTRL_KICK = 1;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {OP_REG_WR, OP_REG_RD, OP_TBL_RD, OP_TBL_WR}
    pfta_op_t;
  typedef enum logic [2:0] {CMD_REG_WR, CMD_REG_RD, CMD_TBL_RD, CMD_TBL_WR,
    CMD_LAUNCH} pfta_cmd_t;
  typedef enum logic [2:0] {REG_PTR_LOW, REG_PTR_HIGH, REG_PTR_UPPER,
    REG_LATCH, REG_CTRL, REG_KEY} pfta_reg_t;
  typedef enum logic [1:0] {PTR_KEEP, PTR_POST_INC, PTR_POST_DEC,
    PTR_PRE_INC} pfta_mode_t;

  // Steps the low field only; the space-select bit rides along
  function automatic logic [ADDR_W-1:0] pfta_step(
    input logic [ADDR_W-1:0] p, input logic up);
    logic [LOW_W-1:0] low;
    low = up ? p[LOW_W-1:0] + 21'h000001 : p[LOW_W-1:0] - 21'h000001;
    return {p[ADDR_W-1], low};
  endfunction
endpackage

// ===== pfta_if.sv
// Link between the processor end and the flash table access end
interface pfta_if;
  import pfta_pkg::*;
  logic req_valid;
  logic req_ready;
  pfta_op_t req_op;
  pfta_reg_t req_reg;
  pfta_mode_t req_mode;
  logic [7:0] req_wdata;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic stall;

  modport dev (
    input req_valid, req_op, req_reg, req_mode, req_wdata,
    output req_ready, rsp_valid, rsp_rdata, stall
  );
  modport cpu (
    output req_valid, req_op, req_reg, req_mode, req_wdata,
    input req_ready, rsp_valid, rsp_rdata, stall
  );
endinterface

// ===== pfta_op_timer.sv
// Self-timed countdown for erase and program long writes
module pfta_op_timer (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic [pfta_pkg::CNT_W-1:0] count_i,
  output logic active_o,
  output logic done_o
);
  import pfta_pkg::*;

  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt <= '0;
      active_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !active_o)
      begin
        cnt <= count_i;
        active_o <= 1'b1;
      end
      else if (active_o)
      begin
        if (cnt <= CNT_W'(1))
        begin
          active_o <= 1'b0;
          done_o <= 1'b1;
        end
        cnt <= cnt - CNT_W'(1);
      end
    end
  end
endmodule

// ===== pfta_cpu_end.sv
// Processor end: issues table and register requests, runs the unlock
module pfta_cpu_end (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  pfta_if.cpu LINK,
  input wire logic CMD_VALID_I,
  input wire pfta_pkg::pfta_cmd_t CMD_KIND_I,
  input wire pfta_pkg::pfta_reg_t CMD_REG_I,
  input wire pfta_pkg::pfta_mode_t CMD_MODE_I,
  input wire logic [7:0] CMD_DATA_I,
  output logic CMD_READY_O,
  output logic RSP_VALID_O,
  output logic [7:0] RSP_DATA_O,
  output logic STALL_O
);
  import pfta_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_KEY1, ST_KEY2, ST_KICK}
    pfta_cpu_st_t;

  pfta_cpu_st_t state;
  logic [7:0] ctrl_val;

  assign CMD_READY_O = state == ST_IDLE && !LINK.stall;
  assign STALL_O = LINK.stall;
  assign LINK.req_valid = state != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // Launch runs key, key, kick back to back so nothing slips between
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state <= ST_IDLE;
      ctrl_val <= ZERO_BYTE;
      LINK.req_op <= OP_REG_RD;
      LINK.req_reg <= REG_PTR_LOW;
      LINK.req_mode <= PTR_KEEP;
      LINK.req_wdata <= ZERO_BYTE;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (CMD_VALID_I && CMD_READY_O)
          begin
            LINK.req_reg <= CMD_REG_I;
            LINK.req_mode <= CMD_MODE_I;
            LINK.req_wdata <= CMD_DATA_I;
            ctrl_val <= CMD_DATA_I;
            state <= ST_ISSUE;
            case (CMD_KIND_I)
              CMD_REG_WR: LINK.req_op <= OP_REG_WR;
              CMD_REG_RD: LINK.req_op <= OP_REG_RD;
              CMD_TBL_RD: LINK.req_op <= OP_TBL_RD;
              CMD_TBL_WR: LINK.req_op <= OP_TBL_WR;
              CMD_LAUNCH:
              begin
                LINK.req_op <= OP_REG_WR;
                LINK.req_reg <= REG_KEY;
                LINK.req_wdata <= KEY_FIRST;
                state <= ST_KEY1;
              end
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_KEY1:
          if (LINK.req_ready)
          begin
            LINK.req_wdata <= KEY_SECOND;
            state <= ST_KEY2;
          end
        ST_KEY2:
          if (LINK.req_ready)
          begin
            LINK.req_reg <= REG_CTRL;
            LINK.req_wdata <= ctrl_val | (8'h01 << CTRL_KICK);
            state <= ST_KICK;
          end
        ST_ISSUE, ST_KICK:
          if (LINK.req_ready)
            state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      RSP_VALID_O <= 1'b0;
      RSP_DATA_O <= ZERO_BYTE;
    end
    else
    begin
      RSP_VALID_O <= LINK.rsp_valid;
      if (LINK.rsp_valid)
        RSP_DATA_O <= LINK.rsp_rdata;
    end
  end
endmodule

// ===== pfta_assertions.sv
// Concurrent checks on the link between processor end and flash end
module pfta_assertions (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pfta_pkg::pfta_op_t req_op,
  input wire pfta_pkg::pfta_reg_t req_reg,
  input wire pfta_pkg::pfta_mode_t req_mode,
  input wire logic [7:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  input wire logic stall
);
  import pfta_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock tracker: any other take breaks the key pair
  logic [1:0] key_state;
  logic [1:0] next_key;
  wire take = req_valid && req_ready;
  wire ctrl_wr = take && req_op == OP_REG_WR && req_reg == REG_CTRL
    && req_wdata[CTRL_KICK];
  wire armed = key_state == 2'h2 && req_wdata[CTRL_ALLOW];
  wire key_wr = req_op == OP_REG_WR && req_reg == REG_KEY;

  always_comb
  begin
    next_key = 2'h0;
    if (key_wr && req_wdata == KEY_FIRST)
      next_key = 2'h1;
    else if (key_wr && req_wdata == KEY_SECOND && key_state == 2'h1)
      next_key = 2'h2;
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      key_state <= 2'h0;
    else if (take)
      key_state <= next_key;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  a_unlock_launch: assert property (ctrl_wr && armed |=> stall)
    else $error("unlocked launch did not stall");
  a_bad_launch_ignored: assert property (
    ctrl_wr && !armed && !stall |=> !stall)
    else $error("launch without unlock or allow started");
  a_stall_blocks: assert property (stall |-> !req_ready)
    else $error("request accepted during long write");
  a_stall_bounded: assert property (
    $rose(stall) |-> stall [*8] ##[1:300] !stall)
    else $error("long write length out of range");
  a_table_rd_answer: assert property (
    take && req_op == OP_TBL_RD |-> ##2 rsp_valid)
    else $error("table read answer late");
  a_table_rd_bubble: assert property (
    take && req_op == OP_TBL_RD |=> !req_ready)
    else $error("no bubble after table read");
  a_reg_rd_answer: assert property (
    take && req_op == OP_REG_RD |=> rsp_valid)
    else $error("register read answer late");
  a_rsp_has_cause: assert property (
    rsp_valid |-> $past(take && req_op == OP_REG_RD)
      || $past(take && req_op == OP_TBL_RD, 2))
    else $error("answer without request");
  a_upper_masked: assert property (
    take && req_op == OP_REG_RD && req_reg == REG_PTR_UPPER
      |=> rsp_rdata[7:6] == 2'b00)
    else $error("upper pointer byte top bits set");
  a_key_reads_zero: assert property (
    take && req_op == OP_REG_RD && req_reg == REG_KEY
      |=> rsp_rdata == ZERO_BYTE)
    else $error("key register read not zero");

  c_launch: cover property (ctrl_wr && armed);
  c_refused: cover property (ctrl_wr && !armed);
  c_table_rd: cover property (take && req_op == OP_TBL_RD);
endmodule

// ===== program_flash_table_access_tb.sv
// Self-checking bench: processor end and flash end joined by the link
module program_flash_table_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfta_pkg::*;

  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  pfta_cmd_t cmd_kind = CMD_REG_WR;
  pfta_reg_t cmd_reg = REG_PTR_LOW;
  pfta_mode_t cmd_mode = PTR_KEEP;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, stall_o;
  logic [7:0] rsp_data, rd;
  logic [21:0] flash_rd_addr, ptr;
  logic [15:0] flash_rd_data;
  logic flash_erase, flash_prog, flash_prog_word, flash_busy, last_word;
  logic [11:0] flash_block, last_blk;
  logic [5:0] flash_word_ofs, last_ofs;
  logic [511:0] flash_prog_data;
  logic [511:0] hold_exp = '0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int prog_cnt = 0;
  int erase_cnt = 0;

  always #2.5 sys_clk = ~sys_clk;

  pfta_if link();
  pfta_flash_dev #(.ERASE_TIME_US(1), .PROG_TIME_US(1)) i_pfta_flash_dev (
    .SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .LINK(link),
    .FLASH_RD_ADDR_O(flash_rd_addr), .FLASH_RD_DATA_I(flash_rd_data),
    .FLASH_ERASE_O(flash_erase), .FLASH_PROG_O(flash_prog),
    .FLASH_PROG_WORD_O(flash_prog_word), .FLASH_BLOCK_O(flash_block),
    .FLASH_WORD_OFS_O(flash_word_ofs), .FLASH_PROG_DATA_O(flash_prog_data),
    .FLASH_BUSY_O(flash_busy));
  pfta_cpu_end i_pfta_cpu_end (
    .SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .LINK(link),
    .CMD_VALID_I(cmd_valid), .CMD_KIND_I(cmd_kind), .CMD_REG_I(cmd_reg),
    .CMD_MODE_I(cmd_mode), .CMD_DATA_I(cmd_data), .CMD_READY_O(cmd_ready),
    .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data), .STALL_O(stall_o));
  pfta_assertions i_pfta_assertions (
    .SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_op(link.req_op),
    .req_reg(link.req_reg), .req_mode(link.req_mode),
    .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid),
    .rsp_rdata(link.rsp_rdata), .stall(link.stall));

  ////////////////////////////////////////////////////////////////////////////
  // Flash array model: content follows the address, space bit included
  function automatic logic [15:0] mem_word(input logic [21:0] a);
    return {a[8:1] ^ 8'hC3, a[8:1] ^ {a[21], 7'h00}};
  endfunction
  function automatic logic [7:0] mem_byte(input logic [21:0] a);
    logic [15:0] w;
    w = mem_word(a);
    return a[0] ? w[15:8] : w[7:0];
  endfunction
  function automatic logic [21:0] step(input logic [21:0] p, input logic up);
    return {p[21], up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001};
  endfunction
  assign flash_rd_data = mem_word(flash_rd_addr);

  // Pulses sampled mid-cycle, away from the launching edge
  always @(negedge sys_clk)
  begin
    cycles++;
    if (flash_prog === 1'b1)
    begin
      prog_cnt++;
      last_blk = flash_block;
      last_word = flash_prog_word;
      last_ofs = flash_word_ofs;
    end
    if (flash_erase === 1'b1)
    begin
      erase_cnt++;
      last_blk = flash_block;
    end
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered and left at a falling edge
  task automatic cmd(input pfta_cmd_t k, input pfta_reg_t r,
    input pfta_mode_t m, input logic [7:0] d);
    int n;
    n = 0;
    cmd_kind <= k;
    cmd_reg <= r;
    cmd_mode <= m;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    while (cmd_ready !== 1'b1 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid <= 1'b0;
    @(negedge sys_clk);
    if (k == CMD_REG_RD || k == CMD_TBL_RD)
    begin
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20)
      begin
        @(negedge sys_clk);
        n++;
      end
      rd = rsp_data;
      @(negedge sys_clk);
    end
  endtask

  task automatic set_ptr(input logic [21:0] p);
    ptr = p;
    cmd(CMD_REG_WR, REG_PTR_LOW, PTR_KEEP, p[7:0]);
    cmd(CMD_REG_WR, REG_PTR_HIGH, PTR_KEEP, p[15:8]);
    cmd(CMD_REG_WR, REG_PTR_UPPER, PTR_KEEP, {2'b00, p[21:16]});
  endtask

  task automatic tbl_rd(input pfta_mode_t m);
    if (m == PTR_PRE_INC)
      ptr = step(ptr, 1'b1);
    cmd(CMD_TBL_RD, REG_LATCH, m, 8'h00);
    chk_val(rd, mem_byte(ptr));
    chk_val(flash_rd_addr, ptr);
    if (m == PTR_POST_INC)
      ptr = step(ptr, 1'b1);
    if (m == PTR_POST_DEC)
      ptr = step(ptr, 1'b0);
  endtask

  task automatic tbl_wr(input pfta_mode_t m, input logic [7:0] d);
    cmd(CMD_REG_WR, REG_LATCH, PTR_KEEP, d);
    if (m == PTR_PRE_INC)
      ptr = step(ptr, 1'b1);
    hold_exp[ptr[5:0] * 8 +: 8] = d;
    cmd(CMD_TBL_WR, REG_LATCH, m, 8'h00);
    if (m == PTR_POST_INC)
      ptr = step(ptr, 1'b1);
  endtask

  task automatic launch(input logic [7:0] c, input int ep, input int ee);
    int p0, e0, n;
    p0 = prog_cnt;
    e0 = erase_cnt;
    n = 0;
    cmd(CMD_LAUNCH, REG_CTRL, PTR_KEEP, c);
    repeat (4) @(negedge sys_clk);
    chk_val(stall_o, (ep + ee) > 0);
    chk_val(flash_busy, (ep + ee) > 0);
    while (stall_o !== 1'b0 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_val(prog_cnt - p0, ep);
    chk_val(erase_cnt - e0, ee);
  endtask

  task automatic chk_hold();
    for (int i = 0; i < 16; i++)
      chk_val(flash_prog_data[32 * i +: 32], hold_exp[32 * i +: 32]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_pointer();
    set_ptr({1'b1, 21'h1FFFFF});
    cmd(CMD_REG_RD, REG_PTR_UPPER, PTR_KEEP, 8'h00);
    chk_val(rd, 8'h3F);
    tbl_rd(PTR_POST_INC);
    tbl_rd(PTR_KEEP);
    tbl_rd(PTR_POST_DEC);
    tbl_rd(PTR_PRE_INC);
    tbl_rd(PTR_PRE_INC);
    cmd(CMD_REG_RD, REG_LATCH, PTR_KEEP, 8'h00);
    chk_val(rd, mem_byte(ptr));
    cmd(CMD_REG_RD, REG_PTR_HIGH, PTR_KEEP, 8'h00);
    chk_val(rd, ptr[15:8]);
    cmd(CMD_REG_RD, REG_PTR_LOW, PTR_KEEP, 8'h00);
    chk_val(rd, ptr[7:0]);
    cmd(CMD_REG_RD, REG_PTR_UPPER, PTR_KEEP, 8'h00);
    chk_val(rd, {2'b00, ptr[21:16]});
    cmd(CMD_REG_RD, REG_KEY, PTR_KEEP, 8'h00);
    chk_val(rd, 8'h00);
  endtask

  task automatic test_block_prog();
    set_ptr(22'h000440);
    for (int i = 0; i < 64; i++)
      tbl_wr(PTR_POST_INC, 8'(i) ^ 8'hA5);
    chk_val(prog_cnt + erase_cnt, 0);
    launch(8'h04, 1, 0);
    chk_val(last_blk, 12'h001);
    chk_val(last_word, 1'b0);
    chk_hold();
    cmd(CMD_REG_RD, REG_CTRL, PTR_KEEP, 8'h00);
    chk_val(rd, 8'h04);
  endtask

  task automatic test_word_prog();
    set_ptr(22'h000802);
    tbl_wr(PTR_POST_INC, 8'h3C);
    tbl_wr(PTR_KEEP, 8'hC3);
    launch(8'h24, 1, 0);
    chk_val(last_word, 1'b1);
    chk_val(last_ofs, 6'h02);
    chk_val(last_blk, 12'h002);
    chk_hold();
  endtask

  task automatic test_erase();
    set_ptr(22'h3FFFFF);
    launch(8'h14, 0, 1);
    chk_val(last_blk, 12'hFFF);
    cmd(CMD_REG_RD, REG_CTRL, PTR_KEEP, 8'h00);
    chk_val(rd, 8'h04);
  endtask

  task automatic test_refused();
    int p0;
    launch(8'h00, 0, 0);
    launch(8'h10, 0, 0);
    p0 = prog_cnt + erase_cnt;
    cmd(CMD_REG_WR, REG_CTRL, PTR_KEEP, 8'h06);
    cmd(CMD_REG_WR, REG_KEY, PTR_KEEP, 8'h55);
    cmd(CMD_REG_WR, REG_KEY, PTR_KEEP, 8'hAA);
    cmd(CMD_REG_WR, REG_PTR_LOW, PTR_KEEP, 8'h00);
    cmd(CMD_REG_WR, REG_CTRL, PTR_KEEP, 8'h06);
    repeat (4) @(negedge sys_clk);
    chk_val(stall_o, 1'b0);
    chk_val(prog_cnt + erase_cnt, p0);
  endtask

  initial
  begin
    repeat (10) @(negedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    test_pointer();
    test_block_prog();
    test_word_prog();
    test_erase();
    test_refused();
    conclude();
  end
endmodule
